// ===== pkg/agu_cfg.svh
`ifndef AGU_CFG_SVH
`define AGU_CFG_SVH
`define AGU_OFF_BREV     12'h000
`define AGU_OFF_PAGE     12'h004
`define AGU_OFF_CIRC     12'h008
`define AGU_OFF_START    12'h00C
`define AGU_OFF_END      12'h010
`define AGU_OFF_CORE     12'h014
`define AGU_REVERSAL_ENABLE_BIT     15
`define AGU_PSV_BIT      2
`define AGU_STACK_PTR    4'hF
`define AGU_RST_BREV     16'h0000
`define AGU_RST_PAGE     8'h00
`define AGU_RST_CIRC     16'h000F
`define AGU_RST_ADDR     16'h0000
`define AGU_RST_CORE     16'h0000
`define AGU_PSV_SIMPLE   2'h1
`define AGU_PSV_OTHER    2'h2
`endif

// ===== pkg/agu_pkg.sv
package agu_pkg;
	typedef enum logic [2:0] {
		AGU_MODE_DIRECT = 3'h1,
		AGU_MODE_PREPOST = 3'h2,
		AGU_MODE_OFFSET = 3'h4
	} agu_mode_t;
	typedef struct packed {
		logic        valid;
		logic        is_write;
		logic        is_x_unit;
		logic        is_byte;
		logic        increment;
		agu_mode_t   mode;
		logic [3:0]  ptr_idx;
		logic [15:0] ptr;
		logic [15:0] step;
		logic        simple_move;
		logic        in_repeat;
		logic        repeat_edge;
		logic        table_op;
	} agu_req_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic        wb_en;
		logic [15:0] wb_value;
		logic        prog_en;
		logic [22:0] prog_addr;
		logic [1:0]  stall;
	} agu_rsp_t;
endpackage : agu_pkg

// ===== rtl/agu_core.sv
`timescale 1ns/1ps
`include "agu_cfg.svh"
module agu_core (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire agu_pkg::agu_req_t req,
	output agu_pkg::agu_rsp_t     rsp,
	input  wire logic [23:0]      prog_word,
	output logic      [15:0]      prog_data
);
	import agu_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] brev;
		logic [7:0]  page;
		logic [15:0] circ;
		logic [15:0] start_a;
		logic [15:0] end_a;
		logic [15:0] core;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		agu_rsp_t    rsp;
		logic [15:0] prog_data;
	} agu_state_t;

	agu_state_t st;
	agu_state_t next_st;

	// ****************************************
	// Bus decode signals
	// ****************************************
	logic        apb_setup;
	logic        apb_access;
	logic        apb_commit;
	logic        apb_hit;
	logic [31:0] apb_rdata;
	logic        wr_brev;
	logic        wr_page;
	logic        wr_circ;
	logic        wr_start;
	logic        wr_end;
	logic        wr_core;

	// ****************************************
	// Address path signals
	// ****************************************
	logic [3:0]  sel_ptr;
	logic        circ_en;
	logic        rev_en;
	logic        inc_mode;
	logic        x_word_write;
	logic        brev_on;
	logic        circ_on;
	logic [15:0] pivot;
	logic [15:0] rev_sum;
	logic [16:0] rev_carry;
	logic [15:0] ea_lin;
	logic [15:0] ea_up;
	logic [15:0] ea_down;
	logic        over_end;
	logic        under_start;
	logic [15:0] ea_wrap;
	logic [15:0] ea_final;
	logic        wb_on;
	logic [15:0] wb_val;

	// ****************************************
	// Program window signals
	// ****************************************
	logic        map_on;
	logic [22:0] map_addr;
	logic [1:0]  stall_cnt;
	agu_rsp_t    rsp_next;

	// ****************************************
	// Register bus phases
	// ****************************************
	// Answer is prepared at the setup edge so ready comes from a flop;
	// the write itself waits for the edge at which ready is seen high
	always_comb begin
		apb_setup  = psel && !penable;
		apb_access = psel && penable;
		apb_commit = apb_access && st.pready && !st.pslverr && pwrite;
	end

	// ****************************************
	// Read data and address check
	// ****************************************
	always_comb begin
		apb_hit   = 1'b1;
		apb_rdata = 32'h0000_0000;
		case (paddr)
			`AGU_OFF_BREV: begin
				apb_rdata = {16'h0000, st.brev};
			end
			`AGU_OFF_PAGE: begin
				apb_rdata = {24'h000000, st.page};
			end
			`AGU_OFF_CIRC: begin
				apb_rdata = {16'h0000, st.circ};
			end
			`AGU_OFF_START: begin
				apb_rdata = {16'h0000, st.start_a};
			end
			`AGU_OFF_END: begin
				apb_rdata = {16'h0000, st.end_a};
			end
			`AGU_OFF_CORE: begin
				apb_rdata = {16'h0000, st.core};
			end
			default: begin
				apb_hit = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Write strobes
	// ****************************************
	// Unmapped offsets never reach a register: the error flag blocks the commit
	always_comb begin
		wr_brev  = apb_commit && (paddr == `AGU_OFF_BREV);
		wr_page  = apb_commit && (paddr == `AGU_OFF_PAGE);
		wr_circ  = apb_commit && (paddr == `AGU_OFF_CIRC);
		wr_start = apb_commit && (paddr == `AGU_OFF_START);
		wr_end   = apb_commit && (paddr == `AGU_OFF_END);
		wr_core  = apb_commit && (paddr == `AGU_OFF_CORE);
	end

	// ****************************************
	// Mode qualification
	// ****************************************
	// The circular select field picks the circular pointer; for reversal it only blocks when it names the stack pointer
	always_comb begin
		sel_ptr      = st.circ[3:0];
		circ_en      = st.circ[15];
		rev_en       = st.brev[`AGU_REVERSAL_ENABLE_BIT] && (sel_ptr != `AGU_STACK_PTR);
		inc_mode     = req.increment && (req.mode == AGU_MODE_PREPOST);
		x_word_write = req.is_x_unit && req.is_write && !req.is_byte;
		brev_on      = rev_en && inc_mode && x_word_write;
		// Reversal wins on X word writes; X reads and X byte writes keep the circular correction
		circ_on      = circ_en && (req.ptr_idx == sel_ptr) && !brev_on;
	end

	// ****************************************
	// Reverse-carry adder
	// ****************************************
	// Carries ripple from the msb downward, which equals reversing both operands,
	// adding and reversing back; the pointer itself stays in normal order
	assign pivot         = {st.brev[14:0], 1'b0};
	assign rev_carry[16] = 1'b0;
	generate
		for (genvar i = 0; i < 16; i++) begin : g_rev_bit
			assign rev_sum[i]   = req.ptr[i] ^ pivot[i] ^ rev_carry[i + 1];
			assign rev_carry[i] = (req.ptr[i] & pivot[i]) | (rev_carry[i + 1] & (req.ptr[i] ^ pivot[i]));
		end
	endgenerate

	// ****************************************
	// Linear and circular address
	// ****************************************
	always_comb begin
		ea_lin = req.ptr;
		if (req.mode != AGU_MODE_DIRECT) begin
			ea_lin = 16'(req.ptr + req.step);
		end
	end

	// Compare beyond the bounds, not for equality, so long steps still wrap
	always_comb begin
		over_end    = req.increment && (ea_lin > st.end_a);
		under_start = !req.increment && (ea_lin < st.start_a);
		ea_up       = 16'(ea_lin - st.end_a + st.start_a - 16'h0001);
		ea_down     = 16'(ea_lin + st.end_a - st.start_a + 16'h0001);
		ea_wrap     = ea_lin;
		if (circ_on && (req.mode != AGU_MODE_DIRECT)) begin
			if (over_end) begin
				ea_wrap = ea_up;
			end else if (under_start) begin
				ea_wrap = ea_down;
			end
		end
	end

	// ****************************************
	// Final address
	// ****************************************
	// Reversed addresses are word aligned; the step of the mode is unused then
	always_comb begin
		ea_final = ea_wrap;
		if (brev_on) begin
			ea_final = rev_sum & 16'hFFFE;
		end
	end

	// ****************************************
	// Pointer write-back
	// ****************************************
	// Offset mode corrects the access only; the pointer stays put
	always_comb begin
		wb_on  = req.valid && (req.mode == AGU_MODE_PREPOST);
		wb_val = ea_final;
	end

	// ****************************************
	// Program memory window
	// ****************************************
	// Table operations use their own path to program memory, so the window closes
	always_comb begin
		map_on   = req.valid && ea_final[15]
			&& st.core[`AGU_PSV_BIT] && !req.table_op;
		map_addr = {st.page, ea_final[14:0]};
	end

	// ****************************************
	// Stall count
	// ****************************************
	// The core supplies the loop position; inside a loop only the edges pay twice, the inner passes pay nothing
	always_comb begin
		stall_cnt = 2'h0;
		if (map_on) begin
			if (req.in_repeat) begin
				if (req.repeat_edge) begin
					stall_cnt = `AGU_PSV_OTHER;
				end else begin
					stall_cnt = 2'h0;
				end
			end else if (req.simple_move) begin
				stall_cnt = `AGU_PSV_SIMPLE;
			end else begin
				stall_cnt = `AGU_PSV_OTHER;
			end
		end
	end

	// ****************************************
	// Response
	// ****************************************
	always_comb begin
		rsp_next           = '0;
		rsp_next.valid     = req.valid;
		rsp_next.addr      = ea_final;
		rsp_next.wb_en     = wb_on;
		rsp_next.wb_value  = wb_val;
		rsp_next.prog_en   = map_on;
		rsp_next.prog_addr = map_addr;
		rsp_next.stall     = stall_cnt;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st         = st;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		if (apb_setup) begin
			next_st.pready  = 1'b1;
			next_st.pslverr = !apb_hit;
			next_st.prdata  = apb_rdata;
		end
		if (wr_brev) begin
			next_st.brev = pwdata[15:0];
		end
		if (wr_page) begin
			next_st.page = pwdata[7:0];
		end
		if (wr_circ) begin
			next_st.circ = pwdata[15:0];
		end
		if (wr_start) begin
			next_st.start_a = pwdata[15:0];
		end
		if (wr_end) begin
			next_st.end_a = pwdata[15:0];
		end
		if (wr_core) begin
			next_st.core = pwdata[15:0];
		end
		next_st.rsp       = rsp_next;
		next_st.prog_data = prog_word[15:0];
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st         <= '0;
			st.pready  <= 1'b0;
			st.pslverr <= 1'b0;
			st.brev    <= `AGU_RST_BREV;
			st.page    <= `AGU_RST_PAGE;
			st.circ    <= `AGU_RST_CIRC;
			st.start_a <= `AGU_RST_ADDR;
			st.end_a   <= `AGU_RST_ADDR;
			st.core    <= `AGU_RST_CORE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata    = st.prdata;
	assign pready    = st.pready;
	assign pslverr   = st.pslverr;
	assign rsp       = st.rsp;
	assign prog_data = st.prog_data;
endmodule : agu_core

// ===== tb/agu_core_asserts.sv
`timescale 1ns/1ps
module agu_core_asserts (
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire agu_pkg::agu_req_t req,
	input wire agu_pkg::agu_rsp_t rsp,
	input wire logic [23:0]       prog_word,
	input wire logic [15:0]       prog_data
);
	import agu_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence setup_s; psel && !penable; endsequence
	sequence hit_s; rsp.prog_en; endsequence
	AST_APB_READY: assert property (setup_s |=> pready && penable) else $error("late ready");
	AST_ERR_READY: assert property (pslverr |-> pready) else $error("lone error");
	AST_MAP_TOP: assert property (hit_s |-> rsp.addr[15]) else $error("low half mapped");
	AST_MAP_ADDR: assert property (hit_s |-> rsp.prog_addr[14:0] == rsp.addr[14:0]) else $error("map addr");
	AST_LOW_WORD: assert property ($past(rst_n) |-> prog_data == $past(prog_word[15:0])) else $error("data");
	AST_TABLE_OFF: assert property (req.valid && req.table_op |=> !rsp.prog_en) else $error("map in table");
	AST_STALL_OUT: assert property ((hit_s and !$past(req.in_repeat)) |->
		rsp.stall == ($past(req.simple_move) ? 2'h1 : 2'h2)) else $error("stall");
	AST_STALL_RPT: assert property ((hit_s and $past(req.in_repeat)) |->
		rsp.stall == ($past(req.repeat_edge) ? 2'h2 : 2'h0)) else $error("repeat stall");
endmodule : agu_core_asserts
bind agu_core agu_core_asserts i_agu_core_asserts (.*);

// ===== tb/agu_prog_mem.sv
`timescale 1ns/1ps
module agu_prog_mem (
	input  wire agu_pkg::agu_rsp_t rsp,
	output logic [23:0]            prog_word
);
	import agu_pkg::*;
	// Top byte all ones acts as a no-op; inverted when unselected so stale data cannot pass
	assign prog_word = {24{!rsp.prog_en}} ^ {8'hFF, rsp.prog_addr[15:0] ^ 16'h5A5A};
endmodule : agu_prog_mem

// ===== tb/agu_core_tb_top.sv
`timescale 1ns/1ps
`include "agu_cfg.svh"
module agu_core_tb_top;
	import agu_pkg::*;
	logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [23:0] prog_word;
	logic [15:0] prog_data;
	agu_req_t    req = '0, r;
	agu_rsp_t    rsp, o;
	int          mismatches = 0, tests_run = 0;
	agu_core i_agu_core (.*);
	agu_prog_mem i_agu_prog_mem (.rsp(rsp), .prog_word(prog_word));
	initial forever #2.5 core_clk = ~core_clk;
	task wrap_up;
		if (mismatches == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge core_clk);
		penable <= 1;
		n = 0;
		@(negedge core_clk);
		while (pready !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		@(posedge core_clk);
		{psel, penable} <= 2'h0;
		if (pready !== 1'b1) begin
			chk(0, 1);
			wrap_up;
		end
	endtask : apb
	task send;
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req <= '0;
		#1 o = rsp;
		@(posedge core_clk);
		#1;
	endtask : send
	task t_psv;
		apb(1, `AGU_OFF_PAGE, 32'h3D);
		apb(1, `AGU_OFF_CORE, 32'h4);
		r = '0;
		r.valid = 1;
		r.mode = AGU_MODE_DIRECT;
		r.ptr = 16'h8123;
		r.simple_move = 1;
		send;
		chk(o.prog_addr, {8'h3D, 15'h0123});
		chk(o.stall, 2'h1);
		chk(prog_data, 16'hDB79);
		r.simple_move = 0;
		send;
		chk(o.stall, 2'h2);
		r.in_repeat = 1;
		send;
		chk(o.stall, 2'h0);
		r.repeat_edge = 1;
		send;
		chk(o.stall, 2'h2);
		r.table_op = 1;
		send;
		chk(o.prog_en, 0);
	endtask : t_psv
	task t_circ;
		apb(0, `AGU_OFF_CIRC, 0);
		chk(rd, 32'h000F);
		apb(1, 12'h0FC, 32'hFFFF);
		chk(er, 1);
		apb(1, `AGU_OFF_START, 32'h1000);
		apb(1, `AGU_OFF_END, 32'h101F);
		apb(1, `AGU_OFF_CIRC, 32'h8003);
		r = '0;
		r.valid = 1;
		r.is_x_unit = 1;
		r.increment = 1;
		r.mode = AGU_MODE_PREPOST;
		r.ptr_idx = 4'h3;
		r.ptr = 16'h101E;
		r.step = 16'h4;
		send;
		chk({o.wb_en, o.addr}, 17'h11002);
		r.mode = AGU_MODE_OFFSET;
		send;
		chk({o.wb_en, o.addr}, 17'h01002);
	endtask : t_circ
	task t_brev;
		apb(1, `AGU_OFF_BREV, 32'h8008);
		r.mode = AGU_MODE_PREPOST;
		r.is_write = 1;
		r.ptr = 16'h2000;
		r.step = 16'h2;
		send;
		chk(o.addr, 16'h2010);
		r.ptr = 16'h0F00;
		r.is_byte = 1;
		send;
		chk(o.addr, 16'h0F02);
		r.is_write = 0;
		r.is_byte = 0;
		send;
		chk(o.addr, 16'h0F02);
	endtask : t_brev
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		t_psv;
		t_circ;
		t_brev;
		wrap_up;
	end
endmodule : agu_core_tb_top
